// [design/adc_conversion_control.v]
// Conversion control of the two-channel successive-comparison converter
`timescale 1ns/1ns
`include "adc_conv_regs.vh"

module adc_conversion_control (
   mclk,
   rst_b,
   sfrAddr,
   sfrWrData,
   sfrWrite,
   sfrRdData,
   convIrqEnable,
   sampleBit,
   analogSelFirst,
   sampleHold,
   dacCode,
   converterPowered,
   coreStall,
   irqHold,
   convIrq
);
   input wire mclk;
   input wire rst_b;
   input wire [7:0] sfrAddr;
   input wire [7:0] sfrWrData;
   input wire sfrWrite;
   output reg [7:0] sfrRdData;
   input wire convIrqEnable;
   input wire sampleBit;
   output reg analogSelFirst;
   output reg sampleHold;
   output reg [`RESULT_WIDTH-1:0] dacCode;
   output reg converterPowered;
   output reg coreStall;
   output reg irqHold;
   output reg convIrq;

   localparam ST_IDLE = 2'h0;
   localparam ST_SAMPLE = 2'h1;
   localparam ST_CONVERT = 2'h2;

   // ==========================================================
   // Reset release
   reg rstMeta_r;
   reg rstSync_b;
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rstMeta_r <= 1'b0;
         rstSync_b <= 1'b0;
      end else begin
         rstMeta_r <= 1'b1;
         rstSync_b <= rstMeta_r;
      end
   end

   // ==========================================================
   // Registers and sequencer state
   reg stall_r;
   reg enable_r;
   reg done_r;
   reg start_r;
   reg chSel_r;
   reg [`CLKDIV_WIDTH-1:0] clockDiv_r;
   reg [7:0] resultHigh_r;
   reg [1:0] resultLow_r;
   reg [1:0] state_r;
   reg [3:0] period_r;
   reg [`RESULT_WIDTH-1:0] trial_r;
   reg [`RESULT_WIDTH-1:0] trial_nxt;
   reg [3:0] bitIdx_r;
   wire tick;
   wire ctrlWrite;
   wire divWrite;
   wire launch;
   wire finish;

   assign ctrlWrite = sfrWrite && (sfrAddr == `CONTROL_ADDR);
   assign divWrite = sfrWrite && (sfrAddr == `CLOCK_DIV_ADDR);
   // A start while busy or disabled is ignored
   assign launch = ctrlWrite && sfrWrData[`CTRL_START_BIT] && !start_r && enable_r;
   assign finish = (state_r == ST_CONVERT) && tick && (period_r == `CONV_PERIODS - 4'h1);

   // ==========================================================
   // Trial code for the next converter period; the DAC sees it on the same edge as the sequencer
   always @* begin
      trial_nxt = trial_r;
      if ((state_r == ST_IDLE) && launch) begin
         trial_nxt = {1'b1, {(`RESULT_WIDTH-1){1'b0}}};
      end else if ((state_r == ST_CONVERT) && start_r && tick) begin
         // Keep or drop the trial bit, then try the next lower one
         if (!sampleBit) begin
            trial_nxt[bitIdx_r] = 1'b0;
         end
         if (bitIdx_r != 4'h0) begin
            trial_nxt[bitIdx_r - 4'h1] = 1'b1;
         end
      end
   end

   conv_clock_gen #(
      .WIDTH(`CLKDIV_WIDTH)
   ) u_clock (
      .mclk(mclk),
      .rstSync_b(rstSync_b),
      .run(start_r),
      .divField(clockDiv_r),
      .tick(tick)
   );

   // ==========================================================
   // Control and divider registers
   always @(posedge mclk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         stall_r <= 1'b0;
         enable_r <= 1'b0;
         done_r <= 1'b0;
         start_r <= 1'b0;
         chSel_r <= 1'b0;
         clockDiv_r <= {`CLKDIV_WIDTH{1'b0}};
      end else begin
         if (divWrite) begin
            clockDiv_r <= sfrWrData[`CLKDIV_WIDTH-1:0];
         end
         if (ctrlWrite) begin
            enable_r <= sfrWrData[`CTRL_ENABLE_BIT];
            if (!start_r) begin
               chSel_r <= sfrWrData[`CTRL_CHSEL_BIT];
               stall_r <= sfrWrData[`CTRL_STALL_BIT];
            end
            // Software may only clear the flag; writing one keeps it
            if (!sfrWrData[`CTRL_DONE_BIT]) begin
               done_r <= 1'b0;
            end
         end
         if (launch) begin
            start_r <= 1'b1;
         end
         if (finish) begin
            start_r <= 1'b0;
            stall_r <= 1'b0;
            done_r <= 1'b1;
         end else if (start_r && ctrlWrite && !sfrWrData[`CTRL_ENABLE_BIT]) begin
            // Disabling aborts an ongoing conversion
            start_r <= 1'b0;
            stall_r <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Successive comparison over eleven converter periods
   always @(posedge mclk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         state_r <= ST_IDLE;
         period_r <= 4'h0;
         trial_r <= {`RESULT_WIDTH{1'b0}};
         bitIdx_r <= 4'h0;
         resultHigh_r <= 8'h00;
         resultLow_r <= 2'h0;
      end else begin
         trial_r <= trial_nxt;
         case (state_r)
            ST_IDLE: begin
               period_r <= 4'h0;
               if (launch) begin
                  state_r <= ST_SAMPLE;
                  bitIdx_r <= 4'h9;
               end
            end
            ST_SAMPLE: begin
               if (!start_r) begin
                  state_r <= ST_IDLE;
               end else if (tick) begin
                  period_r <= period_r + 4'h1;
                  state_r <= ST_CONVERT;
               end
            end
            ST_CONVERT: begin
               if (!start_r) begin
                  state_r <= ST_IDLE;
               end else if (tick) begin
                  period_r <= period_r + 4'h1;
                  if (finish) begin
                     // Both bytes change on the same edge; the last bit is decided here
                     resultHigh_r <= trial_nxt[9:2];
                     resultLow_r <= trial_nxt[1:0];
                     state_r <= ST_IDLE;
                  end else if (bitIdx_r != 4'h0) begin
                     bitIdx_r <= bitIdx_r - 4'h1;
                  end
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Outputs and register read-back
   always @(posedge mclk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         analogSelFirst <= 1'b0;
         sampleHold <= 1'b0;
         dacCode <= {`RESULT_WIDTH{1'b0}};
         converterPowered <= 1'b0;
         coreStall <= 1'b0;
         irqHold <= 1'b0;
         convIrq <= 1'b0;
         sfrRdData <= 8'h00;
      end else begin
         analogSelFirst <= chSel_r;
         sampleHold <= (state_r == ST_SAMPLE);
         dacCode <= trial_nxt;
         converterPowered <= enable_r;
         // The core and interrupts are held via coreStall and irqHold; this block and the others keep running
         coreStall <= (stall_r && start_r) || (launch && sfrWrData[`CTRL_STALL_BIT]);
         irqHold <= (stall_r && start_r) || (launch && sfrWrData[`CTRL_STALL_BIT]);
         convIrq <= (done_r || finish) && convIrqEnable;
         case (sfrAddr)
            `CONTROL_ADDR: sfrRdData <= {1'b0, stall_r, enable_r, done_r, start_r, 2'b00, chSel_r};
            `CLOCK_DIV_ADDR: sfrRdData <= {3'b000, clockDiv_r};
            `RESULT_HIGH_ADDR: sfrRdData <= resultHigh_r;
            `RESULT_LOW_ADDR: sfrRdData <= {6'b000000, resultLow_r};
            default: sfrRdData <= 8'h00;
         endcase
      end
   end
endmodule

// [design/conv_clock_gen.v]
// Converter clock divider: one-cycle tick every factor peripheral clocks
`timescale 1ns/1ns
module conv_clock_gen #(
   parameter WIDTH = 5
) (
   mclk,
   rstSync_b,
   run,
   divField,
   tick
);
   input wire mclk;
   input wire rstSync_b;
   input wire run;
   input wire [WIDTH-1:0] divField;
   output reg tick;

   reg [WIDTH:0] count_r;
   wire [WIDTH:0] factor;

   // Zero in the field means the largest factor
   assign factor = (divField == {WIDTH{1'b0}}) ? {1'b1, {WIDTH{1'b0}}} : {1'b0, divField};

   always @(posedge mclk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         count_r <= {(WIDTH+1){1'b0}};
         tick <= 1'b0;
      end else if (!run) begin
         count_r <= {(WIDTH+1){1'b0}};
         tick <= 1'b0;
      end else if (count_r >= factor - {{WIDTH{1'b0}}, 1'b1}) begin
         count_r <= {(WIDTH+1){1'b0}};
         tick <= 1'b1;
      end else begin
         count_r <= count_r + {{WIDTH{1'b0}}, 1'b1};
         tick <= 1'b0;
      end
   end
endmodule

// [include/adc_conv_regs.vh]
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADC_CONV_REGS_VH
`define ADC_CONV_REGS_VH
// Special function register addresses (byte offsets in the register space)
`define CLOCK_DIV_ADDR 8'hF2
`define CONTROL_ADDR 8'hF3
`define RESULT_LOW_ADDR 8'hF4
`define RESULT_HIGH_ADDR 8'hF5
// Control register fields
`define CTRL_STALL_BIT 6
`define CTRL_ENABLE_BIT 5
`define CTRL_DONE_BIT 4
`define CTRL_START_BIT 3
`define CTRL_CHSEL_BIT 0
`define CTRL_RESET 8'h00
`define CLKDIV_RESET 8'h00
`define CLKDIV_WIDTH 5
// Divider value zero stands for this factor
`define DIV_ZERO_FACTOR 6'h20
// Converter clock periods from launch to result
`define CONV_PERIODS 4'hB
`define RESULT_WIDTH 10
`endif

// [tb/adc_conversion_control_chk.sv]
// Port-level assertions of the conversion control
`timescale 1ns/1ns
module adc_conversion_control_chk (
   input wire mclk,
   input wire rst_b,
   input wire [7:0] sfrAddr,
   input wire [7:0] sfrWrData,
   input wire sfrWrite,
   input wire [7:0] sfrRdData,
   input wire convIrqEnable,
   input wire analogSelFirst,
   input wire coreStall,
   input wire irqHold,
   input wire convIrq
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   wire clrDone = sfrWrite && sfrAddr == 8'hF3 && !sfrWrData[4];
   a_hold_tracks: assert property (irqHold == coreStall)
      else $error("irq hold differs from core stall");
   a_low_zero: assert property ($past(sfrAddr) == 8'hF4 |-> sfrRdData[7:2] == 6'h00)
      else $error("low byte upper bits not zero");
   a_start_reads: assert property ($past(coreStall) && coreStall && $past(sfrAddr) == 8'hF3 |->
      sfrRdData[6] && sfrRdData[3])
      else $error("start or stall bit not set while busy");
   a_stall_min: assert property ($rose(coreStall) |-> coreStall [*8])
      else $error("stall too short");
   a_stall_max: assert property ($rose(coreStall) |-> ##[1:360] !coreStall)
      else $error("stall too long");
   a_irq_after: assert property ($fell(coreStall) && convIrqEnable |-> ##[0:1] convIrq)
      else $error("no interrupt after conversion");
   a_irq_sticky: assert property (convIrq && convIrqEnable && !$past(clrDone) |=> convIrq)
      else $error("done flag dropped without software clear");
   a_chan_held: assert property ($past(coreStall) && coreStall |-> $stable(analogSelFirst))
      else $error("channel changed while busy");
   c_stall: cover property ($rose(coreStall));
   c_irq: cover property ($rose(convIrq));
   c_low: cover property ($past(sfrAddr) == 8'hF4 && sfrRdData != 8'h00);
endmodule
bind adc_conversion_control adc_conversion_control_chk chk_u (.*);

// [tb/adc_conversion_control_tb_top.sv]
// Self-checking bench of the conversion control
`timescale 1ns/1ns
module adc_conversion_control_tb_top;
   reg mclk, rst_b, sfrWrite, convIrqEnable, look;
   reg [7:0] sfrAddr, sfrWrData;
   reg [9:0] lvlA, lvlB, lvl;
   reg [4:0] dv;
   wire [7:0] sfrRdData;
   wire [9:0] dacCode;
   wire sampleBit, analogSelFirst, sampleHold, converterPowered, coreStall, irqHold, convIrq;
   integer fail_count, n_tests, seed, i, f, r;
   reg [7:0] expQ[$];
   adc_conversion_control dut_u (.*);
   comparator_model cmp_u (.dacCode(dacCode), .analogSelFirst(analogSelFirst), .levelFirst(lvlA),
      .levelSecond(lvlB), .sampleBit(sampleBit));
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   task chk(input [7:0] e, input [7:0] g);
      begin
         n_tests = n_tests + 1;
         if (g !== e) begin
            fail_count = fail_count + 1;
            $display("[ERR] %0t read %h expected %h", $time, g, e);
         end
      end
   endtask
   task chkPin(input e, input g);
      begin
         n_tests = n_tests + 1;
         if (g !== e) begin
            fail_count = fail_count + 1;
            $display("[ERR] %0t pin %b expected %b", $time, g, e);
         end
      end
   endtask
   // Read data lands one cycle after the address
   always @(posedge mclk) if (look) begin
      #2;
      chk(expQ.pop_front(), sfrRdData);
   end
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(posedge mclk) #1;
         sfrAddr = a;
         sfrWrData = d;
         sfrWrite = 1'b1;
         @(posedge mclk) #1;
         sfrWrite = 1'b0;
      end
   endtask
   task rd(input [7:0] a, input [7:0] e);
      begin
         @(posedge mclk) #1;
         sfrAddr = a;
         expQ.push_back(e);
         look = 1'b1;
         @(posedge mclk) #1;
         look = 1'b0;
      end
   endtask
   task wrap_up;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, fail_count);
         if (fail_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   initial begin
      #400000;
      fail_count = fail_count + 1;
      wrap_up;
   end
   initial begin
      seed = 32'h898A6190;
      fail_count = 0;
      n_tests = 0;
      rst_b = 1'b0;
      sfrWrite = 1'b0;
      look = 1'b0;
      sfrAddr = 8'h00;
      sfrWrData = 8'h00;
      convIrqEnable = 1'b0;
      r = $random(seed);
      lvlA = r[9:0];
      lvlB = r[19:10];
      repeat (3) @(posedge mclk);
      #1 rst_b = 1'b1;
      repeat (3) @(posedge mclk);
      rd(8'h10, 8'h00);
      rd(8'hF3, 8'h00);
      for (i = 0; i < 4; i = i + 1) begin
         dv = (i == 0) ? 5'h00 : (i == 1) ? 5'h01 : (i == 2) ? 5'h1F : r[24:20];
         f = (dv == 5'h00) ? 32 : dv;
         convIrqEnable = i[0];
         lvl = i[0] ? lvlA : lvlB;
         wr(8'hF2, {3'h0, dv});
         wr(8'hF3, {7'h10, i[0]});
         repeat (4) @(posedge mclk);
         wr(8'hF3, {1'b0, i[1], 4'hA, 1'b0, i[0]});
         wr(8'hF3, {1'b0, i[1], 4'hA, 1'b0, ~i[0]});
         rd(8'hF3, {1'b0, i[1], 4'hA, 1'b0, i[0]});
         chkPin(i[1], coreStall);
         repeat (f * 11) @(posedge mclk);
         rd(8'hF5, lvl[9:2]);
         rd(8'hF4, {6'h00, lvl[1:0]});
         rd(8'hF3, {7'h18, i[0]});
         chkPin(1'b0, coreStall);
         chkPin(i[0], convIrq);
         chkPin(1'b1, converterPowered);
         wr(8'hF3, {7'h10, i[0]});
         rd(8'hF3, {7'h10, i[0]});
         rd(8'hF2, {3'h0, dv});
         $display("conversion test %0d ended", i);
      end
      wrap_up;
   end
endmodule

// [tb/comparator_model.sv]
// Analog side stand-in: channel mux, held level and comparator
`timescale 1ns/1ns
module comparator_model (
   input wire [9:0] dacCode,
   input wire analogSelFirst,
   input wire [9:0] levelFirst,
   input wire [9:0] levelSecond,
   output wire sampleBit
);
   wire [9:0] level = analogSelFirst ? levelFirst : levelSecond;
   // Keep the trial bit while the held level is at or above the trial code
   assign sampleBit = level >= dacCode;
endmodule
